/* File: pkg/aso_regs.vh */
// Purpose: register offsets, field positions and reset values for the
//          serial output configuration bank
// Assumes: 13-bit register addresses, 8-bit registers
// Notes:   definitions only; included by bare name
`ifndef ASO_REGS_VH
`define ASO_REGS_VH

// ==========================================================
// addresses
`define ASO_ADDR_W 13
`define ASO_A_DEV_INDEX 13'h0005
`define ASO_A_CLK_DIV 13'h000B
`define ASO_A_OUT_MODE 13'h0014
`define ASO_A_OUT_ADJUST 13'h0015
`define ASO_A_OUT_PHASE 13'h0016
`define ASO_A_SER_CTRL 13'h0021
`define ASO_A_TRANSFER 13'h00FF
`define ASO_A_RES_OVR 13'h0100
`define ASO_A_UIO_TWO 13'h0101
`define ASO_A_UIO_THREE 13'h0102

// ==========================================================
// writable bit masks (open bits ignore writes, read zero)
`define ASO_M_DEV_INDEX 8'h3F
`define ASO_M_CLK_DIV 8'h07
`define ASO_M_OUT_MODE 8'h01
`define ASO_M_OUT_ADJUST 8'h31
`define ASO_M_OUT_PHASE 8'h7F
`define ASO_M_SER_CTRL 8'hFF
`define ASO_M_RES_OVR 8'h77
`define ASO_M_UIO_TWO 8'h01
`define ASO_M_UIO_THREE 8'h08

// ==========================================================
// reset values
`define ASO_R_DEV_INDEX 8'h3F
`define ASO_R_CLK_DIV 8'h00
`define ASO_R_OUT_MODE 8'h01
`define ASO_R_OUT_ADJUST 8'h00
`define ASO_R_OUT_PHASE 8'h00
`define ASO_R_SER_CTRL 8'h30
`define ASO_R_RES_OVR 8'h00
`define ASO_R_UIO 8'h00

// ==========================================================
// field positions
`define ASO_F_FORMAT 0
`define ASO_F_DRIVE 0
`define ASO_F_TERM_LO 4
`define ASO_F_CLKSEL_LO 4
`define ASO_F_FRAME2X 2
`define ASO_F_OVR_EN 6
`define ASO_F_PD_DIS 0
`define ASO_F_VCM_PD 3
`define ASO_F_XFER 0
`define ASO_F_LSB_FIRST 7
`define ASO_F_PLL_LOW 3
`define ASO_F_MODE_LO 4
`define ASO_F_WORD_LO 0
`define ASO_F_RES_LO 4
`define ASO_F_RATE_LO 0
`define ASO_F_IN_PH_LO 4
`define ASO_F_OUT_PH_LO 0
`define ASO_F_CHAN_LO 0
// last defined data clock phase step, 11 x 60 degrees
`define ASO_DCLK_PH_MAX 4'hB

// ==========================================================
// serial data modes (bits 6:4 of serialization register)
`define ASO_MODE_SDR_BIT 3'h0
`define ASO_MODE_SDR_BYTE 3'h1
`define ASO_MODE_DDR_BIT 3'h2
`define ASO_MODE_DDR_BYTE 3'h3
`define ASO_MODE_ONE_WORD 3'h4
`define ASO_WORD_12 2'h2
`define ASO_RES_12 2'h2

`endif

/* File: design/aso_spi_port.v */
// Purpose: three-wire serial control port front end
// Assumes: sclk, csb and sdio inputs synchronous to i_mclk and slower
//          than half its rate
// Notes:   one instruction plus one data byte per frame
`timescale 1ns/1ps
`include "aso_regs.vh"

module aso_spi_port (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_sclk,
  input wire i_csb_n,
  input wire i_sdio,
  output reg o_sdio,
  output reg o_sdio_oe,
  output reg o_wr,
  output reg [`ASO_ADDR_W-1:0] o_addr,
  output reg [7:0] o_wdata,
  input wire [7:0] i_rdata
);

  reg sclk_q;
  reg [4:0] cnt_q;
  reg [14:0] shift_q;
  reg rnw_q;
  reg load_q;
  reg [7:0] out_q;
  wire rise;
  wire fall;

  assign rise = i_sclk & ~sclk_q;
  assign fall = ~i_sclk & sclk_q;

  // ==========================================================
  // frame engine: 16 instruction bits then 8 data bits
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sclk_q <= 1'b0;
      cnt_q <= 5'h00;
      shift_q <= 15'h0000;
      rnw_q <= 1'b0;
      load_q <= 1'b0;
      out_q <= 8'h00;
      o_sdio <= 1'b0;
      o_sdio_oe <= 1'b0;
      o_wr <= 1'b0;
      o_addr <= 13'h0000;
      o_wdata <= 8'h00;
    end else begin
      sclk_q <= i_sclk;
      o_wr <= 1'b0;
      load_q <= 1'b0;
      // read data fetched one cycle after address is latched
      if (load_q) begin
        out_q <= i_rdata;
      end
      if (i_csb_n) begin
        cnt_q <= 5'h00;
        o_sdio_oe <= 1'b0;
      end else if (rise && cnt_q < 5'd24) begin
        shift_q <= {shift_q[13:0], i_sdio};
        cnt_q <= cnt_q + 5'd1;
        if (cnt_q == 5'd15) begin
          rnw_q <= shift_q[14];
          o_addr <= {shift_q[11:0], i_sdio};
          load_q <= shift_q[14];
        end
        if (cnt_q == 5'd23 && !rnw_q) begin
          o_wr <= 1'b1;
          o_wdata <= {shift_q[6:0], i_sdio};
        end
      end else if (fall && rnw_q && cnt_q >= 5'd16) begin
        // drive on falling edge so host samples on the rising one
        o_sdio <= out_q[7];
        out_q <= {out_q[6:0], 1'b0};
        o_sdio_oe <= (cnt_q < 5'd24);
      end
    end
  end

endmodule // aso_spi_port

/* File: design/aso_serial_output_config.v */
// Purpose: configuration bank for the serial output path of a
//          multichannel converter, reached over the serial control port
// Assumes: i_mclk is the applied sample clock at 125 MHz; serial port
//          pins synchronous to it
// Notes:   all outputs registered; drive bits held per clock channel
//
// Summary of operation
// - format bit 1 twos complement, 0 offset
// - two bits pick output driver termination
// - drive bit sets clock outputs 1x/2x
// - termination overrides double drive on clocks
// - input phase picks sample cycle under divider
// - phase codes delay zero to seven cycles
// - output clock phase twelve 60-degree steps
// - override applies only after transfer strobe
// - override limits rate, resolution, not sampling
// - bit writes disable data pin pull-down
// - bit powers down common-mode reference
// - serialization resets to 0x30 default mode
// - serialization codes decode to lane modes
// - index bits select per-channel write targets
// - other registers take effect on write
`timescale 1ns/1ps
`include "aso_regs.vh"

module aso_serial_output_config (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_sclk,
  input wire i_csb_n,
  input wire i_sdio,
  output wire o_sdio,
  output wire o_sdio_oe,
  input wire [13:0] i_sample,
  output reg [13:0] o_sample,
  output reg o_sample_strobe,
  output reg o_twos_complement,
  output reg [1:0] o_termination,
  output reg [1:0] o_clk_drive_2x,
  output reg [3:0] o_channel_select,
  output reg [2:0] o_input_phase,
  output reg [3:0] o_data_clock_phase,
  output reg o_lsb_first,
  output reg o_pll_low_rate,
  output reg o_frame_clock_2x,
  output reg o_serial_word_length_12,
  output reg o_lane_ddr,
  output reg o_lane_bytewise,
  output reg o_single_lane,
  output reg [3:0] o_lane_rate_mult,
  output reg o_ovr_enable,
  output reg [1:0] o_ovr_resolution,
  output reg [2:0] o_ovr_rate,
  output reg o_pulldown_disable,
  output reg o_common_mode_reference_pd
);

  // ==========================================================
  // lane bit rate multiple of the sample rate for a mode
  function [3:0] lane_rate;
    input [2:0] mode;
    input [1:0] bits;
    reg twelve;
    begin
      twelve = (bits == `ASO_WORD_12);
      case (mode)
        `ASO_MODE_DDR_BIT,
        `ASO_MODE_DDR_BYTE: lane_rate = twelve ? 4'd3 : 4'd4;
        `ASO_MODE_SDR_BIT,
        `ASO_MODE_SDR_BYTE,
        `ASO_MODE_ONE_WORD: lane_rate = twelve ? 4'd6 : 4'd8;
        default: lane_rate = 4'd0;
      endcase
    end
  endfunction

  // ==========================================================
  // lane shape for a mode: {ddr, bytewise, single lane}
  function [2:0] lane_flags;
    input [2:0] mode;
    begin
      case (mode)
        `ASO_MODE_SDR_BIT: lane_flags = 3'h0;
        `ASO_MODE_SDR_BYTE: lane_flags = 3'h2;
        `ASO_MODE_DDR_BIT: lane_flags = 3'h4;
        `ASO_MODE_DDR_BYTE: lane_flags = 3'h6;
        `ASO_MODE_ONE_WORD: lane_flags = 3'h5;
        default: lane_flags = 3'h0;
      endcase
    end
  endfunction

  // ==========================================================
  // serial port front end
  wire wr;
  wire [`ASO_ADDR_W-1:0] addr;
  wire [7:0] wdata;
  reg [7:0] rdata;

  aso_spi_port u_port (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_sclk(i_sclk),
    .i_csb_n(i_csb_n),
    .i_sdio(i_sdio),
    .o_sdio(o_sdio),
    .o_sdio_oe(o_sdio_oe),
    .o_wr(wr),
    .o_addr(addr),
    .o_wdata(wdata),
    .i_rdata(rdata)
  );

  // ==========================================================
  // register storage
  reg [7:0] dev_index_q;
  reg [7:0] clk_div_q;
  reg [7:0] out_mode_q;
  reg [7:0] out_adjust_q;
  reg [1:0] drive_q;
  reg [7:0] out_phase_q;
  reg [7:0] ser_ctrl_q;
  reg [7:0] ovr_staged_q;
  reg [7:0] ovr_active_q;
  reg [7:0] uio_two_q;
  reg [7:0] uio_three_q;
  reg [2:0] div_cnt_q;
  reg [2:0] div_cnt_d;
  wire [1:0] clk_sel;
  wire xfer;

  assign clk_sel = dev_index_q[`ASO_F_CLKSEL_LO+1:`ASO_F_CLKSEL_LO];
  assign xfer = wr && (addr == `ASO_A_TRANSFER) && wdata[`ASO_F_XFER];

  // ==========================================================
  // field slices of the stored registers
  wire [2:0] ser_mode;
  wire [1:0] ser_bits;
  wire [2:0] in_phase;
  wire [3:0] out_phase;
  wire [1:0] ovr_res;
  wire [2:0] ovr_rate;
  wire [2:0] lane_kind;

  assign ser_mode = ser_ctrl_q[`ASO_F_MODE_LO+2:`ASO_F_MODE_LO];
  assign ser_bits = ser_ctrl_q[`ASO_F_WORD_LO+1:`ASO_F_WORD_LO];
  assign in_phase = out_phase_q[`ASO_F_IN_PH_LO+2:`ASO_F_IN_PH_LO];
  assign out_phase = out_phase_q[`ASO_F_OUT_PH_LO+3:`ASO_F_OUT_PH_LO];
  assign ovr_res = ovr_active_q[`ASO_F_RES_LO+1:`ASO_F_RES_LO];
  assign ovr_rate = ovr_active_q[`ASO_F_RATE_LO+2:`ASO_F_RATE_LO];
  assign lane_kind = lane_flags(ser_mode);

  // ==========================================================
  // writes land immediately except the staged override
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      dev_index_q <= `ASO_R_DEV_INDEX;
      clk_div_q <= `ASO_R_CLK_DIV;
      out_mode_q <= `ASO_R_OUT_MODE;
      out_adjust_q <= `ASO_R_OUT_ADJUST;
      drive_q <= 2'b00;
      out_phase_q <= `ASO_R_OUT_PHASE;
      ser_ctrl_q <= `ASO_R_SER_CTRL;
      ovr_staged_q <= `ASO_R_RES_OVR;
      uio_two_q <= `ASO_R_UIO;
      uio_three_q <= `ASO_R_UIO;
    end else if (wr) begin
      case (addr)
        `ASO_A_DEV_INDEX: begin
          dev_index_q <= wdata & `ASO_M_DEV_INDEX;
        end
        `ASO_A_CLK_DIV: begin
          clk_div_q <= wdata & `ASO_M_CLK_DIV;
        end
        `ASO_A_OUT_MODE: begin
          out_mode_q <= wdata & `ASO_M_OUT_MODE;
        end
        `ASO_A_OUT_ADJUST: begin
          out_adjust_q <= wdata & `ASO_M_OUT_ADJUST;
          // drive applies only to selected clock channels
          if (clk_sel[0]) begin
            drive_q[0] <= wdata[`ASO_F_DRIVE];
          end
          if (clk_sel[1]) begin
            drive_q[1] <= wdata[`ASO_F_DRIVE];
          end
        end
        `ASO_A_OUT_PHASE: begin
          out_phase_q <= wdata & `ASO_M_OUT_PHASE;
        end
        `ASO_A_SER_CTRL: begin
          ser_ctrl_q <= wdata & `ASO_M_SER_CTRL;
        end
        `ASO_A_RES_OVR: begin
          ovr_staged_q <= wdata & `ASO_M_RES_OVR;
        end
        `ASO_A_UIO_TWO: begin
          uio_two_q <= wdata & `ASO_M_UIO_TWO;
        end
        `ASO_A_UIO_THREE: begin
          uio_three_q <= wdata & `ASO_M_UIO_THREE;
        end
        default: begin
          // unmapped and transfer writes store nothing
        end
      endcase
    end
  end

  // ==========================================================
  // override shadow: copied only on the transfer strobe
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ovr_active_q <= `ASO_R_RES_OVR;
    end else if (xfer) begin
      ovr_active_q <= ovr_staged_q;
    end
  end

  // ==========================================================
  // read mux; transfer self-clears, unmapped reads zero
  always @* begin
    rdata = 8'h00;
    case (addr)
      `ASO_A_DEV_INDEX: rdata = dev_index_q;
      `ASO_A_CLK_DIV: rdata = clk_div_q;
      `ASO_A_OUT_MODE: rdata = out_mode_q;
      `ASO_A_OUT_ADJUST: begin
        // drive bit reads back from the lowest selected clock channel
        rdata = out_adjust_q & 8'hFE;
        if (clk_sel[0]) begin
          rdata[`ASO_F_DRIVE] = drive_q[0];
        end else if (clk_sel[1]) begin
          rdata[`ASO_F_DRIVE] = drive_q[1];
        end
      end
      `ASO_A_OUT_PHASE: rdata = out_phase_q;
      `ASO_A_SER_CTRL: rdata = ser_ctrl_q;
      `ASO_A_RES_OVR: rdata = ovr_staged_q;
      `ASO_A_UIO_TWO: rdata = uio_two_q;
      `ASO_A_UIO_THREE: rdata = uio_three_q;
      default: rdata = 8'h00;
    endcase
  end

  // ==========================================================
  // input clock divider counter, wraps at the programmed ratio
  always @* begin
    div_cnt_d = div_cnt_q + 3'd1;
    if (div_cnt_q >= clk_div_q[2:0]) begin
      div_cnt_d = 3'd0;
    end
  end

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      div_cnt_q <= 3'd0;
      o_sample_strobe <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      // phase only matters with the divider on; a phase above the
      // ratio never matches, so the strobe stalls
      if (clk_div_q[2:0] == 3'd0) begin
        o_sample_strobe <= 1'b1;
      end else begin
        o_sample_strobe <= (div_cnt_q == in_phase);
      end
    end
  end

  // ==========================================================
  // sample word coding: offset binary in, flip msb for twos
  // complement; override may trim to 12 bits but never touches the
  // sampling strobe above
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_sample <= 14'h0000;
    end else begin
      o_sample <= i_sample ^ {out_mode_q[`ASO_F_FORMAT], 13'h0000};
      if (ovr_active_q[`ASO_F_OVR_EN] &&
          ovr_res == `ASO_RES_12) begin
        o_sample[1:0] <= 2'b00;
      end
    end
  end

  // ==========================================================
  // registered configuration outputs
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_twos_complement <= 1'b0;
      o_termination <= 2'b00;
      o_clk_drive_2x <= 2'b00;
      o_channel_select <= 4'h0;
      o_input_phase <= 3'd0;
      o_data_clock_phase <= 4'h0;
      o_lsb_first <= 1'b0;
      o_pll_low_rate <= 1'b0;
      o_frame_clock_2x <= 1'b0;
      o_serial_word_length_12 <= 1'b0;
      o_lane_ddr <= 1'b0;
      o_lane_bytewise <= 1'b0;
      o_single_lane <= 1'b0;
      o_lane_rate_mult <= 4'h0;
      o_ovr_enable <= 1'b0;
      o_ovr_resolution <= 2'b00;
      o_ovr_rate <= 3'd0;
      o_pulldown_disable <= 1'b0;
      o_common_mode_reference_pd <= 1'b0;
    end else begin
      o_twos_complement <= out_mode_q[`ASO_F_FORMAT];
      o_termination <=
        out_adjust_q[`ASO_F_TERM_LO+1:`ASO_F_TERM_LO];
      // any termination wins over double clock drive
      if (out_adjust_q[`ASO_F_TERM_LO+1:`ASO_F_TERM_LO] != 2'b00) begin
        o_clk_drive_2x <= 2'b00;
      end else begin
        o_clk_drive_2x <= drive_q;
      end
      o_channel_select <=
        dev_index_q[`ASO_F_CHAN_LO+3:`ASO_F_CHAN_LO];
      o_input_phase <= in_phase;
      // codes above the last step are not offsets; held there
      if (out_phase > `ASO_DCLK_PH_MAX) begin
        o_data_clock_phase <= `ASO_DCLK_PH_MAX;
      end else begin
        o_data_clock_phase <= out_phase;
      end
      o_lsb_first <= ser_ctrl_q[`ASO_F_LSB_FIRST];
      o_pll_low_rate <= ser_ctrl_q[`ASO_F_PLL_LOW];
      o_frame_clock_2x <= ser_ctrl_q[`ASO_F_FRAME2X];
      o_serial_word_length_12 <= (ser_bits == `ASO_WORD_12);
      // one decode feeds all three lane shape outputs
      o_lane_ddr <= lane_kind[2];
      o_lane_bytewise <= lane_kind[1];
      o_single_lane <= lane_kind[0];
      o_lane_rate_mult <= lane_rate(ser_mode, ser_bits);
      o_ovr_enable <= ovr_active_q[`ASO_F_OVR_EN];
      o_ovr_resolution <= ovr_res;
      o_ovr_rate <= ovr_rate;
      o_pulldown_disable <= uio_two_q[`ASO_F_PD_DIS];
      o_common_mode_reference_pd <=
        uio_three_q[`ASO_F_VCM_PD];
    end
  end

endmodule // aso_serial_output_config

/* File: bench/aso_capture_model.sv */
// Purpose: far-side capture logic taking sample words on each strobe
// Assumes: shares the converter's sample clock
// Notes:   turns captured words back into offset binary
`timescale 1ns/1ps

// ==========================================================
// capture model
module aso_capture_model (
  input wire i_mclk,
  input wire [13:0] i_sample,
  input wire i_strobe,
  input wire i_twos,
  output reg [13:0] o_word,
  output reg [15:0] o_count
);
  initial begin
    o_word = 14'h0000;
    o_count = 16'h0000;
  end
  // words only land on a strobe, like a real capture register
  always @(posedge i_mclk) begin
    if (i_strobe) begin
      o_word <= {i_sample[13] ^ i_twos, i_sample[12:0]};
      o_count <= o_count + 16'h0001;
    end
  end
endmodule // aso_capture_model

/* File: bench/aso_serial_output_config_props.sv */
// Purpose: port-level properties of the output configuration bank
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to the top module
`timescale 1ns/1ps

// ==========================================================
// checker
module aso_serial_output_config_props (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_csb_n,
  input wire [13:0] i_sample,
  input wire o_sdio_oe,
  input wire [13:0] o_sample,
  input wire o_twos_complement,
  input wire [1:0] o_termination,
  input wire [1:0] o_clk_drive_2x,
  input wire [3:0] o_data_clock_phase,
  input wire o_serial_word_length_12,
  input wire o_lane_ddr,
  input wire o_lane_bytewise,
  input wire o_single_lane,
  input wire [3:0] o_lane_rate_mult,
  input wire o_ovr_enable,
  input wire [1:0] o_ovr_resolution
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // format must be settled two cycles, the datapath lags the bit
  property p_fmt;
    ($stable(o_twos_complement) && $past(i_rst_n, 2))[*2]
      |-> o_sample[13] == ($past(i_sample[13]) ^ o_twos_complement);
  endproperty
  a_fmt: assert property (p_fmt)
    else $error("sample msb does not follow format");
  property p_term;
    o_termination != 2'h0 |-> o_clk_drive_2x == 2'h0;
  endproperty
  a_term: assert property (p_term)
    else $error("double drive active under termination");
  property p_dclk;
    $changed(o_data_clock_phase)
      |-> !$past(i_csb_n, 3) && o_data_clock_phase <= 4'hB;
  endproperty
  a_dclk: assert property (p_dclk)
    else $error("clock phase out of range or unwritten");
  property p_mult;
    o_lane_rate_mult != 4'h0 |-> o_lane_rate_mult ==
      ((o_lane_ddr && !o_single_lane) ?
       (o_serial_word_length_12 ? 4'h3 : 4'h4) :
       (o_serial_word_length_12 ? 4'h6 : 4'h8));
  endproperty
  a_mult: assert property (p_mult)
    else $error("lane rate multiple wrong");
  property p_single;
    o_single_lane |-> o_lane_ddr && !o_lane_bytewise;
  endproperty
  a_single: assert property (p_single)
    else $error("single lane not wordwise ddr");
  property p_trunc;
    (o_ovr_enable && o_ovr_resolution == 2'h2)[*3] |-> o_sample[1:0] == 2'h0;
  endproperty
  a_trunc: assert property (p_trunc)
    else $error("override resolution not applied");
  property p_ovr_write;
    $changed(o_ovr_enable) |-> !$past(i_csb_n, 3);
  endproperty
  a_ovr_write: assert property (p_ovr_write)
    else $error("override changed outside a frame");
  property p_idle;
    $past(i_csb_n) && $past(i_csb_n, 2) |-> !o_sdio_oe;
  endproperty
  a_idle: assert property (p_idle)
    else $error("data pin driven while deselected");
endmodule // aso_serial_output_config_props

bind aso_serial_output_config aso_serial_output_config_props props_u (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_csb_n(i_csb_n),
  .i_sample(i_sample), .o_sdio_oe(o_sdio_oe), .o_sample(o_sample),
  .o_twos_complement(o_twos_complement), .o_termination(o_termination),
  .o_clk_drive_2x(o_clk_drive_2x), .o_data_clock_phase(o_data_clock_phase),
  .o_serial_word_length_12(o_serial_word_length_12),
  .o_lane_ddr(o_lane_ddr), .o_lane_bytewise(o_lane_bytewise),
  .o_single_lane(o_single_lane), .o_lane_rate_mult(o_lane_rate_mult),
  .o_ovr_enable(o_ovr_enable), .o_ovr_resolution(o_ovr_resolution));

/* File: bench/aso_serial_output_config_tb.sv */
// Purpose: self-checking bench for the output configuration bank
// Assumes: serial port driven at 2 high / 3 low mclk cycles per bit
// Notes:   random samples from a fixed seed feed the datapath
`timescale 1ns/1ps
`include "aso_regs.vh"
`define CHK(g, e) begin checked = checked + 1; if ((g) !== (e)) begin \
  mismatches = mismatches + 1; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end

// ==========================================================
// bench
module aso_serial_output_config_tb;
  reg i_mclk, i_rst_n, i_sclk, i_csb_n, host_oe, host_d;
  reg [13:0] i_sample, prev1, prev2;
  reg [31:0] r, q;
  reg [7:0] c;
  reg [15:0] n;
  integer seed, i, checked, mismatches, cycles;
  wire i_sdio, o_sdio, o_sdio_oe, o_sample_strobe, o_twos_complement;
  wire o_lsb_first, o_pll_low_rate, o_frame_clock_2x, o_single_lane;
  wire o_serial_word_length_12, o_lane_ddr, o_lane_bytewise, o_ovr_enable;
  wire o_pulldown_disable, o_common_mode_reference_pd;
  wire [13:0] o_sample, cap_word;
  wire [15:0] cap_count;
  wire [1:0] o_termination, o_clk_drive_2x, o_ovr_resolution;
  wire [3:0] o_channel_select, o_data_clock_phase, o_lane_rate_mult;
  wire [2:0] o_input_phase, o_ovr_rate;
  // released pin: pull-down idles low, high once it is disabled
  assign i_sdio = o_sdio_oe ? o_sdio : (host_oe ? host_d : o_pulldown_disable);

  aso_serial_output_config dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_sclk(i_sclk), .i_csb_n(i_csb_n), .i_sdio(i_sdio), .o_sdio(o_sdio),
    .o_sdio_oe(o_sdio_oe), .i_sample(i_sample), .o_sample(o_sample),
    .o_sample_strobe(o_sample_strobe), .o_twos_complement(o_twos_complement),
    .o_termination(o_termination), .o_clk_drive_2x(o_clk_drive_2x),
    .o_channel_select(o_channel_select), .o_input_phase(o_input_phase),
    .o_data_clock_phase(o_data_clock_phase), .o_lsb_first(o_lsb_first),
    .o_pll_low_rate(o_pll_low_rate), .o_frame_clock_2x(o_frame_clock_2x),
    .o_serial_word_length_12(o_serial_word_length_12),
    .o_lane_ddr(o_lane_ddr), .o_lane_bytewise(o_lane_bytewise),
    .o_single_lane(o_single_lane), .o_lane_rate_mult(o_lane_rate_mult),
    .o_ovr_enable(o_ovr_enable), .o_ovr_resolution(o_ovr_resolution),
    .o_ovr_rate(o_ovr_rate), .o_pulldown_disable(o_pulldown_disable),
    .o_common_mode_reference_pd(o_common_mode_reference_pd));
  aso_capture_model cap_u (.i_mclk(i_mclk), .i_sample(o_sample),
    .i_strobe(o_sample_strobe), .i_twos(o_twos_complement),
    .o_word(cap_word), .o_count(cap_count));

  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  // random samples plus a two-deep history for expectations
  always @(posedge i_mclk) begin
    r = $random(seed);
    i_sample <= r[13:0];
    prev1 <= i_sample;
    prev2 <= prev1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      close_out;
    end
  end

  // one frame: instruction word then a data byte, msb first
  task spi(input rd, input [12:0] a, input [7:0] wd, output [7:0] rv);
    reg [23:0] sh;
    integer k;
    begin
      sh = {rd, 2'b00, a, wd};
      rv = 8'h00;
      i_csb_n <= 1'b0;
      for (k = 23; k >= 0; k = k - 1) begin
        host_d <= sh[k];
        if (rd && k < 8) host_oe <= 1'b0;
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
        if (k < 8) rv[k] = i_sdio;
        @(posedge i_mclk);
        i_sclk <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_sclk <= 1'b0;
      end
      repeat (8) @(posedge i_mclk);
      i_csb_n <= 1'b1;
      host_oe <= 1'b1;
      repeat (3) @(posedge i_mclk);
    end
  endtask
  task wr(input [12:0] a, input [7:0] d);
    reg [7:0] x;
    spi(1'b0, a, d, x);
  endtask
  task rdchk(input [12:0] a, input [7:0] e);
    reg [7:0] x;
    begin
      spi(1'b1, a, 8'h00, x);
      `CHK(x, e)
    end
  endtask
  // expected lane flags {ddr, byte, single, frame2x, w12, mult}
  function [8:0] lane_exp(input [7:0] v);
    reg w;
    begin
      w = (v[1:0] == 2'h2);
      lane_exp = {v[5] | v[6], v[4], v[6], v[2], w,
        (v[5] && !v[6]) ? (w ? 4'h3 : 4'h4) : (w ? 4'h6 : 4'h8)};
    end
  endfunction
  task close_out;
    begin
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // main sequence
  initial begin
    seed = 32'hf821;
    {i_rst_n, i_sclk, host_d} = 3'h0;
    {i_csb_n, host_oe} = 2'h3;
    i_sample = 14'h0000;
    {checked, mismatches, cycles} = 0;
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    `CHK({o_twos_complement, o_input_phase, o_clk_drive_2x}, 6'h20)
    `CHK(o_lane_rate_mult, 4'h4)
    rdchk(`ASO_A_SER_CTRL, 8'h30);
    for (i = 0; i < 2; i = i + 1) begin
      wr(`ASO_A_OUT_MODE, i[7:0]);
      @(negedge i_mclk);
      `CHK(o_sample, {prev1[13] ^ i[0], prev1[12:0]})
      `CHK(cap_word, prev2)
    end
    wr(`ASO_A_OUT_ADJUST, 8'hFF);
    rdchk(`ASO_A_OUT_ADJUST, 8'h31);
    `CHK({o_termination, o_clk_drive_2x}, 4'hC)
    wr(`ASO_A_OUT_ADJUST, 8'h01);
    `CHK({o_termination, o_clk_drive_2x}, 4'h3)
    wr(`ASO_A_DEV_INDEX, 8'h10);
    wr(`ASO_A_OUT_ADJUST, 8'h00);
    `CHK(o_clk_drive_2x, 2'h2)
    q = $random(seed);
    wr(`ASO_A_DEV_INDEX, q[7:0]);
    `CHK(o_channel_select, q[3:0])
    rdchk(`ASO_A_DEV_INDEX, q[7:0] & `ASO_M_DEV_INDEX);
    wr(`ASO_A_CLK_DIV, 8'h03);
    wr(`ASO_A_OUT_PHASE, 8'h25);
    `CHK({o_input_phase, o_data_clock_phase}, 7'h25)
    n = cap_count;
    repeat (16) @(posedge i_mclk);
    `CHK(cap_count - n, 16'h0004)
    wr(`ASO_A_OUT_PHASE, 8'h2E);
    `CHK(o_data_clock_phase, 4'hB)
    wr(`ASO_A_CLK_DIV, 8'h00);
    n = cap_count;
    repeat (16) @(posedge i_mclk);
    `CHK(cap_count - n, 16'h0010)
    wr(`ASO_A_SER_CTRL, 8'hD8);
    `CHK({o_lsb_first, o_pll_low_rate, o_lane_rate_mult}, 6'h30)
    for (i = 0; i < 18; i = i + 1) begin
      c = (i < 16) ? {2'b00, i[1:0], 1'b0, i[3:2], 1'b0} : {6'h10, i[0], 1'b0};
      wr(`ASO_A_SER_CTRL, c);
      `CHK({o_lane_ddr, o_lane_bytewise, o_single_lane, o_frame_clock_2x,
        o_serial_word_length_12, o_lane_rate_mult}, lane_exp(c))
    end
    rdchk(`ASO_A_SER_CTRL, 8'h42);
    wr(`ASO_A_RES_OVR, 8'hE5);
    rdchk(`ASO_A_RES_OVR, 8'h65);
    `CHK({o_ovr_enable, o_ovr_rate}, 4'h0)
    wr(`ASO_A_TRANSFER, 8'h01);
    `CHK({o_ovr_enable, o_ovr_resolution, o_ovr_rate}, 6'h35)
    rdchk(`ASO_A_TRANSFER, 8'h00);
    @(negedge i_mclk);
    `CHK({o_sample[1:0], o_sample_strobe}, 3'h1)
    wr(`ASO_A_UIO_TWO, 8'hFF);
    wr(`ASO_A_UIO_THREE, 8'hFF);
    `CHK({o_pulldown_disable, o_common_mode_reference_pd}, 2'h3)
    rdchk(`ASO_A_UIO_TWO, 8'h01);
    rdchk(`ASO_A_UIO_THREE, 8'h08);
    rdchk(13'h0050, 8'h00);
    close_out;
  end
endmodule // aso_serial_output_config_tb
